//--- common/oaf_pkg.sv
// Types shared by the operand address and flags block
package oaf_pkg;
  typedef enum logic [1:0] {
    OAF_SEG_EXTRA = 2'h0,
    OAF_SEG_CODE = 2'h1,
    OAF_SEG_STACK = 2'h2,
    OAF_SEG_DATA = 2'h3
  } oaf_seg_t;
  typedef enum logic [2:0] {
    OAF_REF_FETCH = 3'h0,
    OAF_REF_STACK = 3'h1,
    OAF_REF_DATA = 3'h2,
    OAF_REF_STRDST = 3'h3,
    OAF_REF_ALTDATA = 3'h4
  } oaf_ref_t;
  typedef enum logic [2:0] {
    OAF_MODE_DIRECT = 3'h0,
    OAF_MODE_INDIRECT = 3'h1,
    OAF_MODE_BASED = 3'h2,
    OAF_MODE_INDEXED = 3'h3,
    OAF_MODE_BIDX = 3'h4,
    OAF_MODE_BIDXD = 3'h5
  } oaf_mode_t;
  typedef enum logic [2:0] {
    OAF_ST_IDLE = 3'b001,
    OAF_ST_ARMED = 3'b010,
    OAF_ST_TRAP = 3'b100
  } oaf_step_t;
endpackage : oaf_pkg

//--- common/oaf_regs.svh
// Register offsets, field positions, reset values for operand address block
`ifndef OAF_REGS_SVH
`define OAF_REGS_SVH
`define OAF_FLAG_OFS 12'h000
`define OAF_STAT_OFS 12'h004
`define OAF_SEG_OFS 12'h008
`define OAF_FLAG_RESET 16'h0002
`define OAF_CF_BIT 0
`define OAF_SF_BIT 7
`define OAF_TF_BIT 8
`define OAF_IF_BIT 9
`define OAF_DF_BIT 10
`define OAF_OF_BIT 11
`define OAF_FLAG_WMASK 16'h0FD5
`define OAF_STEP_VEC 8'h01
`endif

//--- design/oaf_core.sv
// Operand address generation with flag word and APB access
`timescale 1ns/1ps
`include "oaf_regs.svh"
module oaf_core
  import oaf_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Address request from decoder
  input wire logic addr_req,
  input wire oaf_mode_t mode,
  input wire oaf_ref_t ref_kind,
  input wire logic base_is_frame,
  input wire logic index_is_dest,
  input wire logic indirect_is_index,
  input wire logic disp_is_byte,
  input wire logic [15:0] disp,
  input wire logic ovr_valid,
  input wire oaf_seg_t ovr_seg,
  input wire logic [15:0] general_base,
  input wire logic [15:0] frame_base,
  input wire logic [15:0] src_index,
  input wire logic [15:0] dest_index,
  // Address result to translation stage
  output logic addr_valid,
  output oaf_seg_t addr_seg,
  output logic [15:0] addr_offset,
  // Operand source select
  input wire logic opnd_is_imm,
  input wire logic [15:0] imm_value,
  input wire logic [15:0] reg_value,
  output logic [15:0] opnd_value,
  // Result flag update from execution
  input wire logic res_valid,
  input wire logic res_is_word,
  input wire logic res_is_sub,
  input wire logic [15:0] res_opa,
  input wire logic [15:0] res_opb,
  input wire logic [15:0] res_value,
  // Flag load and flag ops from execution
  input wire logic flag_load,
  input wire logic [15:0] flag_load_value,
  input wire logic set_dir,
  input wire logic clr_dir,
  input wire logic set_ie,
  input wire logic clr_ie,
  // String index step
  input wire logic str_step,
  input wire logic str_is_word,
  output logic [15:0] src_index_next,
  output logic [15:0] dest_index_next,
  // Instruction retire and interrupt handling
  input wire logic instr_done,
  input wire logic intr_req,
  input wire logic [7:0] intr_vec,
  output logic int_take,
  output logic [7:0] int_vector,
  // Flag word view
  output logic [15:0] flag_word
);
  logic [15:0] flag_q;
  logic [15:0] flag_d;
  logic [15:0] off_w;
  oaf_seg_t seg_w;
  logic sign_w;
  logic ovf_w;
  oaf_step_t step_q;
  oaf_step_t step_d;
  logic int_take_q;
  logic [7:0] int_vec_q;
  logic addr_valid_q;
  oaf_seg_t addr_seg_q;
  logic [15:0] addr_off_q;
  logic [15:0] opnd_q;
  logic [15:0] stride;
  logic [31:0] prdata_q;
  logic [7:0] int_count_q;
  logic wr_flag;
  logic rd_acc;
  logic trap_fire;
  logic intr_fire;

  // Decode of one aligned APB word address
  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a[11:2] == o[11:2]);
  endfunction : hit

  oaf_offset u_offset (
    .mode(mode),
    .ref_kind(ref_kind),
    .base_is_frame(base_is_frame),
    .index_is_dest(index_is_dest),
    .indirect_is_index(indirect_is_index),
    .disp_is_byte(disp_is_byte),
    .disp(disp),
    .general_base(general_base),
    .frame_base(frame_base),
    .src_index(src_index),
    .dest_index(dest_index),
    .ovr_valid(ovr_valid),
    .ovr_seg(ovr_seg),
    .offset(off_w),
    .seg(seg_w)
  );

  oaf_flag_alu u_flag_alu (
    .is_word(res_is_word),
    .is_sub(res_is_sub),
    .opa(res_opa),
    .opb(res_opb),
    .result(res_value),
    .sign(sign_w),
    .ovf(ovf_w)
  );

  // APB: zero wait states, every access answers at once
  assign pready = 1'b1;
  assign wr_flag = psel && penable && pwrite && hit(paddr, `OAF_FLAG_OFS);
  assign rd_acc = psel && !pwrite;
  assign prdata = prdata_q;

  // Unmapped addresses flag an error in the access phase
  assign pslverr = psel && penable && !hit(paddr, `OAF_FLAG_OFS) &&
                   !hit(paddr, `OAF_STAT_OFS) && !hit(paddr, `OAF_SEG_OFS);

  // Read data captured in setup so it is a flop in the access phase
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      prdata_q <= 32'h0000_0000;
    else if (rd_acc && !penable)
    begin
      if (hit(paddr, `OAF_FLAG_OFS))
        prdata_q <= {16'h0000, flag_q};
      else if (hit(paddr, `OAF_STAT_OFS))
        prdata_q <= {16'h0000, int_vec_q, int_count_q};
      else if (hit(paddr, `OAF_SEG_OFS))
        prdata_q <= {14'h0000, addr_seg_q, addr_off_q};
      else
        prdata_q <= 32'h0000_0000;
    end
  end

  // Trap fires after the instruction following the arming one
  assign trap_fire = (step_q == OAF_ST_ARMED) && flag_q[`OAF_TF_BIT] &&
                     instr_done;
  // Maskable request only with interrupt flag set, trap first
  assign intr_fire = intr_req && flag_q[`OAF_IF_BIT] && instr_done &&
                     !trap_fire;

  // Flag word: software writes lose to hardware updates in that cycle
  always_comb
  begin
    flag_d = flag_q;
    if (wr_flag)
      flag_d = (pwdata[15:0] & `OAF_FLAG_WMASK) | `OAF_FLAG_RESET;
    if (flag_load)
      flag_d = (flag_load_value & `OAF_FLAG_WMASK) | `OAF_FLAG_RESET;
    if (set_dir)
      flag_d[`OAF_DF_BIT] = 1'b1;
    if (clr_dir)
      flag_d[`OAF_DF_BIT] = 1'b0;
    if (set_ie)
      flag_d[`OAF_IF_BIT] = 1'b1;
    if (clr_ie)
      flag_d[`OAF_IF_BIT] = 1'b0;
    if (res_valid)
    begin
      flag_d[`OAF_SF_BIT] = sign_w;
      flag_d[`OAF_OF_BIT] = ovf_w;
    end
    // Taking any interrupt clears trap and interrupt enable
    if (trap_fire || intr_fire)
    begin
      flag_d[`OAF_TF_BIT] = 1'b0;
      flag_d[`OAF_IF_BIT] = 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      flag_q <= `OAF_FLAG_RESET;
    else
      flag_q <= flag_d;
  end

  // Single-step sequencer; arm waits one retire so the setting
  // instruction itself is not trapped
  always_comb
  begin
    step_d = step_q;
    unique case (step_q)
      OAF_ST_IDLE:
        if (flag_q[`OAF_TF_BIT] && instr_done)
          step_d = OAF_ST_ARMED;
      OAF_ST_ARMED:
        if (!flag_q[`OAF_TF_BIT])
          step_d = OAF_ST_IDLE;
        else if (instr_done)
          step_d = OAF_ST_TRAP;
      OAF_ST_TRAP:
        step_d = OAF_ST_IDLE;
      default:
        step_d = OAF_ST_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      step_q <= OAF_ST_IDLE;
    else
      step_q <= step_d;
  end

  // Interrupt take pulse and vector
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      int_take_q <= 1'b0;
      int_vec_q <= 8'h00;
    end
    else
    begin
      int_take_q <= trap_fire || intr_fire;
      if (trap_fire)
        int_vec_q <= `OAF_STEP_VEC;
      else if (intr_fire)
        int_vec_q <= intr_vec;
    end
  end

  // Count of interrupts taken, wraps
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      int_count_q <= 8'h00;
    else if (trap_fire || intr_fire)
      int_count_q <= 8'(int_count_q + 8'h01);
  end

  // Segment id and offset registered side by side
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      addr_valid_q <= 1'b0;
      addr_seg_q <= OAF_SEG_DATA;
      addr_off_q <= 16'h0000;
    end
    else
    begin
      addr_valid_q <= addr_req;
      if (addr_req)
      begin
        addr_seg_q <= seg_w;
        addr_off_q <= off_w;
      end
    end
  end

  // Operand source: immediate or general register
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      opnd_q <= 16'h0000;
    else
      opnd_q <= opnd_is_imm ? imm_value : reg_value;
  end

  // String index step; registers wrap inside the 64K segment
  assign stride = str_is_word ? 16'h0002 : 16'h0001;
  assign src_index_next = !str_step ? src_index :
    flag_q[`OAF_DF_BIT] ? 16'(src_index - stride) :
    16'(src_index + stride);
  assign dest_index_next = !str_step ? dest_index :
    flag_q[`OAF_DF_BIT] ? 16'(dest_index - stride) :
    16'(dest_index + stride);

  assign addr_valid = addr_valid_q;
  assign addr_seg = addr_seg_q;
  assign addr_offset = addr_off_q;
  assign opnd_value = opnd_q;
  assign int_take = int_take_q;
  assign int_vector = int_vec_q;
  assign flag_word = flag_q;

  chk_sign_follows: assert property (@(posedge clock)
    disable iff (!rst_n) res_valid |=> flag_q[`OAF_SF_BIT] ==
    $past(res_is_word ? res_value[15] : res_value[7]))
    else $error("sign flag mismatch");
  chk_ovf_follows: assert property (@(posedge clock)
    disable iff (!rst_n) res_valid |=> flag_q[`OAF_OF_BIT] == $past(ovf_w))
    else $error("overflow flag mismatch");
  chk_trap_clears: assert property (@(posedge clock)
    disable iff (!rst_n) trap_fire |=> !flag_q[`OAF_TF_BIT] && int_take &&
    int_vector == `OAF_STEP_VEC)
    else $error("trap did not clear");
  chk_intr_masked: assert property (@(posedge clock)
    disable iff (!rst_n) instr_done && !flag_q[`OAF_IF_BIT] && !trap_fire |=>
    !int_take)
    else $error("interrupt taken while masked");
  chk_dir_step: assert property (@(posedge clock) disable iff (!rst_n)
    str_step && flag_q[`OAF_DF_BIT] |->
    dest_index_next == 16'(dest_index - (str_is_word ? 16'h0002 : 16'h0001)))
    else $error("direction step wrong");
  chk_fetch_code: assert property (@(posedge clock) disable iff (!rst_n)
    addr_req && ref_kind == OAF_REF_FETCH |=>
    addr_valid && addr_seg == OAF_SEG_CODE)
    else $error("fetch not on code segment");
  chk_frame_stack: assert property (@(posedge clock)
    disable iff (!rst_n) addr_req && !ovr_valid && ref_kind == OAF_REF_DATA &&
    mode == OAF_MODE_BASED && base_is_frame |=> addr_seg == OAF_SEG_STACK)
    else $error("frame base not on stack");
  chk_override_wins: assert property (@(posedge clock)
    disable iff (!rst_n) addr_req && ovr_valid && ref_kind == OAF_REF_DATA
    |=> addr_seg == $past(ovr_seg))
    else $error("override ignored");
  chk_wrap_sum: assert property (@(posedge clock) disable iff (!rst_n)
    addr_req && mode == OAF_MODE_BIDX && !base_is_frame && !index_is_dest
    |=> addr_offset == 16'($past(general_base) + $past(src_index)))
    else $error("offset sum wrong");
  chk_operand_pick: assert property (@(posedge clock)
    disable iff (!rst_n) opnd_is_imm |=> opnd_value == $past(imm_value))
    else $error("operand source wrong");
  cov_trap: cover property (@(posedge clock) disable iff (!rst_n)
    trap_fire);
  cov_intr: cover property (@(posedge clock) disable iff (!rst_n)
    intr_fire);
  cov_override: cover property (@(posedge clock) disable iff (!rst_n)
    addr_req && ovr_valid);
  cov_dec: cover property (@(posedge clock) disable iff (!rst_n)
    str_step && flag_q[`OAF_DF_BIT]);
endmodule : oaf_core

//--- design/oaf_flag_alu.sv
// Sign and overflow derivation from a result
`timescale 1ns/1ps
module oaf_flag_alu
(
  // Operation result
  input wire logic is_word,
  input wire logic is_sub,
  input wire logic [15:0] opa,
  input wire logic [15:0] opb,
  input wire logic [15:0] result,
  // Derived flags
  output logic sign,
  output logic ovf
);
  logic sa;
  logic sb;
  logic sr;

  assign sa = is_word ? opa[15] : opa[7];
  assign sb = (is_word ? opb[15] : opb[7]) ^ is_sub;
  assign sr = is_word ? result[15] : result[7];
  // Top bit of the result width
  assign sign = sr;
  // Signed overflow: like-signed inputs giving another sign
  assign ovf = (sa == sb) && (sr != sa);
endmodule : oaf_flag_alu

//--- design/oaf_offset.sv
// Effective offset adder and default segment picker
`timescale 1ns/1ps
module oaf_offset
  import oaf_pkg::*;
(
  // Operand selection
  input wire oaf_mode_t mode,
  input wire oaf_ref_t ref_kind,
  input wire logic base_is_frame,
  input wire logic index_is_dest,
  input wire logic indirect_is_index,
  input wire logic disp_is_byte,
  input wire logic [15:0] disp,
  // Register contents
  input wire logic [15:0] general_base,
  input wire logic [15:0] frame_base,
  input wire logic [15:0] src_index,
  input wire logic [15:0] dest_index,
  // Override prefix
  input wire logic ovr_valid,
  input wire oaf_seg_t ovr_seg,
  // Results
  output logic [15:0] offset,
  output oaf_seg_t seg
);
  logic [15:0] disp_ext;
  logic [15:0] base_val;
  logic [15:0] idx_val;
  logic base_used;

  // Byte displacement sign extended before the add
  assign disp_ext = disp_is_byte ? {{8{disp[7]}}, disp[7:0]} : disp;
  assign base_val = base_is_frame ? frame_base : general_base;
  assign idx_val = index_is_dest ? dest_index : src_index;

  // Sum of the chosen elements; 16-bit wrap drops carry
  always_comb
  begin
    base_used = 1'b0;
    offset = 16'h0000;
    unique case (mode)
      OAF_MODE_DIRECT: offset = disp_ext;
      OAF_MODE_INDIRECT:
      begin
        offset = indirect_is_index ? idx_val : base_val;
        base_used = !indirect_is_index;
      end
      OAF_MODE_BASED:
      begin
        offset = 16'(base_val + disp_ext);
        base_used = 1'b1;
      end
      OAF_MODE_INDEXED: offset = 16'(idx_val + disp_ext);
      OAF_MODE_BIDX:
      begin
        offset = 16'(base_val + idx_val);
        base_used = 1'b1;
      end
      OAF_MODE_BIDXD:
      begin
        offset = 16'(base_val + idx_val + disp_ext);
        base_used = 1'b1;
      end
      default: offset = disp_ext;
    endcase
  end

  // Implicit segment choice, then prefix override
  always_comb
  begin
    seg = OAF_SEG_DATA;
    if (ref_kind == OAF_REF_FETCH)
      seg = OAF_SEG_CODE;
    else if (ref_kind == OAF_REF_STACK)
      seg = OAF_SEG_STACK;
    else if (ref_kind == OAF_REF_STRDST || ref_kind == OAF_REF_ALTDATA)
      seg = OAF_SEG_EXTRA;
    else if (base_used && base_is_frame)
      seg = OAF_SEG_STACK;
    // Fetch and string destination ignore prefixes
    if (ovr_valid && ref_kind != OAF_REF_FETCH &&
        ref_kind != OAF_REF_STRDST)
      seg = ovr_seg;
  end
endmodule : oaf_offset

//--- testbench/oaf_exec_model.sv
// Execution-side model: pointer registers and a maskable interrupt source
`timescale 1ns/1ps
module oaf_exec_model
  import oaf_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Pointer loading and string stepping
  input wire logic ld,
  input wire logic [63:0] ld_val,
  input wire logic str_step,
  input wire logic [15:0] src_index_next,
  input wire logic [15:0] dest_index_next,
  // Interrupt source control
  input wire logic raise,
  input wire logic [7:0] vec,
  input wire logic int_take,
  // Towards the block
  output logic [15:0] general_base,
  output logic [15:0] frame_base,
  output logic [15:0] src_index,
  output logic [15:0] dest_index,
  output logic intr_req,
  output logic [7:0] intr_vec
);
  // Pointers write back the stepped index values, as execution does
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      {general_base, frame_base, src_index, dest_index} <= 64'h0;
    else if (ld)
      {general_base, frame_base, src_index, dest_index} <= ld_val;
    else if (str_step)
    begin
      src_index <= src_index_next;
      dest_index <= dest_index_next;
    end
  end

  // Request is a level held until any int_take, a trap's included, so a masked one is lost only when a trap is taken
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      intr_req <= 1'b0;
    else if (raise)
      intr_req <= 1'b1;
    else if (int_take)
      intr_req <= 1'b0;
  end

  // Vector follows each new request
  always_ff @(posedge clock)
  begin
    if (raise)
      intr_vec <= vec;
  end
endmodule : oaf_exec_model

//--- testbench/tb_top.sv
// Self-checking bench for the operand address and flags block
`timescale 1ns/1ps
`include "oaf_regs.svh"
module tb_top;
  import oaf_pkg::*;
  // Clock, reset and register bus
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, r;
  logic err, got;
  // Address request and result
  logic addr_req = 1'b0, base_is_frame = 1'b0, index_is_dest = 1'b0;
  logic indirect_is_index = 1'b0, disp_is_byte = 1'b0, ovr_valid = 1'b0;
  oaf_mode_t mode = OAF_MODE_DIRECT;
  oaf_ref_t ref_kind = OAF_REF_DATA;
  oaf_seg_t ovr_seg = OAF_SEG_EXTRA;
  oaf_seg_t addr_seg, eseg;
  logic [15:0] disp = 16'h0, eoff, addr_offset;
  logic [15:0] general_base, frame_base, src_index, dest_index;
  logic addr_valid;
  // Operands, flag updates, string step and interrupts
  logic opnd_is_imm = 1'b0, res_valid = 1'b0, res_is_word = 1'b0;
  logic res_is_sub = 1'b0, flag_load = 1'b0, set_dir = 1'b0, clr_dir = 1'b0;
  logic set_ie = 1'b0, clr_ie = 1'b0, str_step = 1'b0, str_is_word = 1'b0;
  logic [15:0] imm_value = 16'h0, reg_value = 16'h0, opnd_value, flag_word;
  logic [15:0] res_opa = 16'h0, res_opb = 16'h0, res_value = 16'h0;
  logic [15:0] flag_load_value = 16'h0, src_index_next, dest_index_next;
  logic instr_done = 1'b0, intr_req, int_take, ld = 1'b0, raise = 1'b0;
  logic [7:0] intr_vec, int_vector, vec = 8'h0;
  logic [63:0] ld_val = 64'h0;
  int fail_count = 0;
  int tests_run = 0;
  logic [31:0] lfsr = 32'hDC675B9A;

  oaf_core u_dut (
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .addr_req(addr_req), .mode(mode),
    .ref_kind(ref_kind), .base_is_frame(base_is_frame),
    .index_is_dest(index_is_dest), .indirect_is_index(indirect_is_index),
    .disp_is_byte(disp_is_byte), .disp(disp), .ovr_valid(ovr_valid),
    .ovr_seg(ovr_seg), .general_base(general_base),
    .frame_base(frame_base), .src_index(src_index),
    .dest_index(dest_index), .addr_valid(addr_valid),
    .addr_seg(addr_seg), .addr_offset(addr_offset),
    .opnd_is_imm(opnd_is_imm), .imm_value(imm_value),
    .reg_value(reg_value), .opnd_value(opnd_value),
    .res_valid(res_valid), .res_is_word(res_is_word),
    .res_is_sub(res_is_sub), .res_opa(res_opa), .res_opb(res_opb),
    .res_value(res_value), .flag_load(flag_load),
    .flag_load_value(flag_load_value), .set_dir(set_dir),
    .clr_dir(clr_dir), .set_ie(set_ie), .clr_ie(clr_ie),
    .str_step(str_step), .str_is_word(str_is_word),
    .src_index_next(src_index_next), .dest_index_next(dest_index_next),
    .instr_done(instr_done), .intr_req(intr_req), .intr_vec(intr_vec),
    .int_take(int_take), .int_vector(int_vector), .flag_word(flag_word)
  );
  oaf_exec_model u_exec (
    .clock(clock), .rst_n(rst_n), .ld(ld), .ld_val(ld_val),
    .str_step(str_step), .src_index_next(src_index_next),
    .dest_index_next(dest_index_next), .raise(raise), .vec(vec),
    .int_take(int_take), .general_base(general_base),
    .frame_base(frame_base), .src_index(src_index),
    .dest_index(dest_index), .intr_req(intr_req), .intr_vec(intr_vec)
  );

  // Free-running clock, 50 ns period
  always #25 clock = ~clock;

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04C11DB7 : 32'h00000000);
    return lfsr;
  endfunction : rnd

  // Offset from the request fields as they stand now
  function automatic logic [15:0] exp_off();
    logic [15:0] dx, b, x;
    dx = disp_is_byte ? {{8{disp[7]}}, disp[7:0]} : disp;
    b = base_is_frame ? frame_base : general_base;
    x = index_is_dest ? dest_index : src_index;
    case (mode)
      OAF_MODE_DIRECT: return dx;
      OAF_MODE_INDIRECT: return indirect_is_index ? x : b;
      OAF_MODE_BASED: return b + dx;
      OAF_MODE_INDEXED: return x + dx;
      OAF_MODE_BIDX: return b + x;
      default: return b + x + dx;
    endcase
  endfunction : exp_off

  // Fetch and string destination are never overridden
  function automatic oaf_seg_t exp_seg();
    logic fb;
    fb = base_is_frame && mode != OAF_MODE_DIRECT &&
         mode != OAF_MODE_INDEXED &&
         !(mode == OAF_MODE_INDIRECT && indirect_is_index);
    if (ref_kind == OAF_REF_FETCH)
      return OAF_SEG_CODE;
    if (ref_kind == OAF_REF_STRDST)
      return OAF_SEG_EXTRA;
    if (ovr_valid)
      return ovr_seg;
    if (ref_kind == OAF_REF_STACK || (ref_kind == OAF_REF_DATA && fb))
      return OAF_SEG_STACK;
    return (ref_kind == OAF_REF_ALTDATA) ? OAF_SEG_EXTRA : OAF_SEG_DATA;
  endfunction : exp_seg

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  // One register bus transfer; only the watchdog bounds the ready wait
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    // Answer taken at the very edge where ready is seen high
    do
      @(posedge clock);
    while (!pready);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Retire one instruction and watch a few cycles for a taken interrupt
  task automatic done_wait();
    @(posedge clock);
    instr_done <= 1'b1;
    @(posedge clock);
    instr_done <= 1'b0;
    got = 1'b0;
    repeat (4)
    begin
      #1;
      got = got | int_take;
      @(posedge clock);
    end
  endtask : done_wait

  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out

  // Watchdog sized well above the few hundred cycles the tests need
  initial
  begin
    repeat (5000) @(posedge clock);
    fail_count++;
    close_out();
  end

  initial
  begin
    repeat (2) @(posedge clock);
    chk("flag reset", flag_word, `OAF_FLAG_RESET);
    chk("valid reset", addr_valid, 1'b0);
    chk("seg reset", addr_seg, OAF_SEG_DATA);
    rst_n <= 1'b1;
    $display("test reset done");
    // Back-to-back address requests over every mode and kind
    for (int i = 0; i <= 60; i++)
    begin
      @(posedge clock);
      r = rnd();
      addr_req <= (i < 60);
      mode <= oaf_mode_t'(i % 6);
      ref_kind <= oaf_ref_t'((i / 6) % 5);
      base_is_frame <= r[0] && ((i / 6) % 5 != 4);
      index_is_dest <= r[1];
      indirect_is_index <= r[2];
      disp_is_byte <= r[3];
      ovr_valid <= r[4];
      ovr_seg <= oaf_seg_t'(r[6:5]);
      disp <= (i < 6) ? 16'h0080 : r[31:16];
      ld <= (i % 12 == 0);
      ld_val <= (i == 0) ? 64'hFFFF_8000_7FFF_0001 : {rnd(), rnd()};
      #1;
      if (i > 0)
      begin
        chk("valid", addr_valid, 1'b1);
        chk("seg", addr_seg, eseg);
        chk("offset", addr_offset, eoff);
      end
      eoff = exp_off();
      eseg = exp_seg();
    end
    @(posedge clock);
    #1;
    chk("valid idle", addr_valid, 1'b0);
    $display("test address done");
    // Sign and overflow from results, corners first
    for (int i = 0; i < 32; i++)
    begin
      logic w, s, sf, of;
      logic [15:0] a, b, v;
      int k;
      r = rnd();
      w = (i < 2) ? 1'b1 : r[0];
      s = (i == 1) ? 1'b1 : r[1];
      a = (i == 0) ? 16'h7FFF : (i == 1) ? 16'h8000 : r[31:16];
      b = (i < 2) ? 16'h0001 : rnd();
      v = s ? a - b : a + b;
      k = w ? 15 : 7;
      sf = v[k];
      of = (s ? (a[k] != b[k]) : (a[k] == b[k])) && (v[k] != a[k]);
      @(posedge clock);
      res_valid <= 1'b1;
      res_is_word <= w;
      res_is_sub <= s;
      res_opa <= a;
      res_opb <= b;
      res_value <= v;
      @(posedge clock);
      res_valid <= 1'b0;
      #1;
      chk("sign", flag_word[`OAF_SF_BIT], sf);
      chk("overflow", flag_word[`OAF_OF_BIT], of);
    end
    $display("test flags done");
    // Direction flag steps string indexes down, then up, across wrap
    @(posedge clock);
    ld <= 1'b1;
    ld_val <= 64'h1234_5678_0000_FFFF;
    set_dir <= 1'b1;
    @(posedge clock);
    ld <= 1'b0;
    set_dir <= 1'b0;
    str_step <= 1'b1;
    str_is_word <= 1'b1;
    #1;
    chk("dir set", flag_word[`OAF_DF_BIT], 1'b1);
    chk("src down", src_index_next, 16'hFFFE);
    chk("dst down", dest_index_next, 16'hFFFD);
    @(posedge clock);
    str_step <= 1'b0;
    clr_dir <= 1'b1;
    @(posedge clock);
    clr_dir <= 1'b0;
    str_step <= 1'b1;
    str_is_word <= 1'b0;
    #1;
    chk("src up", src_index_next, 16'hFFFF);
    chk("dst up", dest_index_next, 16'hFFFE);
    @(posedge clock);
    str_step <= 1'b0;
    $display("test string done");
    // Flag word over the bus, read-only and unmapped places
    apb(1'b1, `OAF_FLAG_OFS, 32'h0000FFFF);
    chk("wr err", err, 1'b0);
    apb(1'b0, `OAF_FLAG_OFS, 32'h0);
    chk("flag rd", rd, 32'h00000FD7);
    apb(1'b1, `OAF_STAT_OFS, 32'hFFFFFFFF);
    apb(1'b1, 12'hFF0, 32'h0);
    chk("unmapped wr", err, 1'b1);
    apb(1'b0, 12'hFFC, 32'h0);
    chk("unmapped err", err, 1'b1);
    chk("unmapped rd", rd, 32'h0);
    chk("flag kept", flag_word, 16'h0FD7);
    @(posedge clock);
    flag_load <= 1'b1;
    flag_load_value <= 16'h0002;
    @(posedge clock);
    flag_load <= 1'b0;
    #1;
    chk("flag load", flag_word, 16'h0002);
    $display("test bus done");
    // Interrupt enable set, then cleared again by execution
    @(posedge clock);
    set_ie <= 1'b1;
    @(posedge clock);
    set_ie <= 1'b0;
    clr_ie <= 1'b1;
    #1;
    chk("ie set", flag_word[`OAF_IF_BIT], 1'b1);
    @(posedge clock);
    clr_ie <= 1'b0;
    #1;
    chk("ie clr", flag_word[`OAF_IF_BIT], 1'b0);
    // Maskable request ignored while disabled, taken once enabled
    @(posedge clock);
    raise <= 1'b1;
    vec <= 8'h40;
    @(posedge clock);
    raise <= 1'b0;
    done_wait();
    chk("masked", got, 1'b0);
    @(posedge clock);
    set_ie <= 1'b1;
    @(posedge clock);
    set_ie <= 1'b0;
    done_wait();
    chk("taken", got, 1'b1);
    chk("vector", int_vector, 8'h40);
    chk("ie cleared", flag_word[`OAF_IF_BIT], 1'b0);
    $display("test interrupt done");
    // Single step: one instruction runs, the next retire traps
    apb(1'b1, `OAF_FLAG_OFS, 32'h00000100);
    done_wait();
    chk("arm only", got, 1'b0);
    done_wait();
    chk("trap", got, 1'b1);
    chk("trap vec", int_vector, `OAF_STEP_VEC);
    chk("tf cleared", flag_word[`OAF_TF_BIT], 1'b0);
    apb(1'b0, `OAF_STAT_OFS, 32'h0);
    chk("status rd", rd, 32'h00000102);
    $display("test step done");
    // Register or immediate operand source
    for (int i = 0; i < 8; i++)
    begin
      r = rnd();
      @(posedge clock);
      opnd_is_imm <= i[0];
      imm_value <= r[15:0];
      reg_value <= r[31:16];
      @(posedge clock);
      #1;
      chk("operand", opnd_value, i[0] ? r[15:0] : r[31:16]);
    end
    $display("test operand done");
    close_out();
  end
endmodule : tb_top
